// *** cpu_bus_host_port.v ***
// Notes on behaviour
// - Seven-bit address with select and strobe picks a register; service acknowledge is decoded from its own line, not the address.
// - Lane order high: first byte on bits 15:8, second on 7:0.
// - Lane order low: first byte on bits 7:0, second on 15:8.
// - Lane order affects only DMA transfers and DMA buffer writes.
// - Register handshake runs on input clock halved, DMA logic on the full clock; halved clock driven out.
// - Register cycle starts only with chip select and data strobe low.
// - Only DMA and DMA buffer writes move a full sixteen-bit word over the bus lines.
// - Other register writes store only bits 7:0.
// - Register reads drive the byte on both lanes.
// - Transfer acknowledge drives high briefly, then releases.
// - Service request only pulls low or floats.
// - Data strobe latches or enables data in register cycles, ignored in DMA.
// - Acknowledge marks completion, never asserted in DMA cycles.
// - DMA request set by FIFO need while enabled and held; drops at acknowledge fall when last, or when DMA disabled.
`timescale 1ns/100ps
`default_nettype none
`include "host_port_consts.vh"
module cpu_bus_host_port (
	input  wire        core_clk,               // Input clock.
	input  wire        rst,                    // Asynchronous reset, active high.
	output wire        half_clk,               // Halved clock output.
	input  wire [6:0]  reg_addr,               // Register address.
	input  wire        chip_select_n,          // Chip select, active low.
	input  wire        data_strobe_n,          // Data strobe, active low.
	input  wire        read_write,             // High read, low write.
	input  wire        lane_order_select,      // Byte lane order select.
	input  wire [15:0] host_data_bus_in,       // Data bus input.
	output reg  [15:0] host_data_bus_out,      // Data bus output.
	output wire        host_data_bus_oe,       // Data bus output enable.
	output wire        transfer_acknowledge_n_out, // Acknowledge level.
	output wire        transfer_acknowledge_n_oe,  // Acknowledge drive enable.
	output reg         dma_request_n,          // DMA request, active low.
	input  wire        dma_acknowledge_n,      // DMA acknowledge, active low.
	input  wire        dma_enable_bit,         // DMA enabled.
	input  wire        dma_to_memory,          // DMA direction, high toward memory.
	input  wire        fifo_wants_transfer,    // FIFO calls for a transfer.
	input  wire        fifo_last_transfer,     // No transfer may follow this one.
	input  wire [15:0] dma_read_word,          // Two bytes from the FIFO, first in [7:0].
	output reg  [15:0] dma_write_word,         // Two bytes to the FIFO, first in [7:0].
	output reg         dma_write_strobe,       // Pulse with a DMA word for the FIFO.
	input  wire        service_pending,        // Parallel side wants service.
	output wire        service_request_n_out,  // Service request level (always low).
	output wire        service_request_n_oe,   // Service request pull-down enable.
	input  wire        service_acknowledge_n,  // Service acknowledge, active low.
	input  wire        daisy_grant_n,          // Daisy grant, active low.
	output reg         daisy_pass_n,           // Daisy pass, active low.
	output reg         host_busy_reply,        // Parallel reply line.
	output reg         strobe_reply,           // Parallel strobe reply.
	output reg         acknowledge_data_request, // Parallel ack line.
	output reg         extension_flag,         // Parallel extension flag.
	output reg         data_available_n,       // Parallel data available.
	output reg         buffer_direction,       // External buffer direction.
	output reg         buffer_enable,          // External buffer enable.
	output wire        cable_data_lines_oe,    // Cable data drive enable.
	output wire        general_purpose_lines_oe // General lines drive enable.
);
	localparam ST_IDLE = 2'b00;
	localparam ST_DONE = 2'b01;
	localparam ST_REL  = 2'b10;
	localparam ST_WAIT = 2'b11;

	reg        half;
	reg        half_d;
	reg [1:0]  state;
	reg        ack_drive;
	reg        ack_low;
	reg        bus_drive;
	reg        wr_en;
	reg [7:0]  wr_byte;
	reg        dma_ack_d;
	wire [7:0] rd_byte;
	wire       tick = half & ~half_d;
	wire       dma_active = ~dma_acknowledge_n;
	wire       reg_cycle = ~chip_select_n & ~data_strobe_n & dma_acknowledge_n;
	wire       svc_cycle = ~service_acknowledge_n & ~daisy_grant_n & ~data_strobe_n;
	wire       is_dma_buffer_register = (reg_addr == `DMA_BUFFER_ADDR);
	wire [15:0] lane_in = lane_order_select ?
		{host_data_bus_in[7:0], host_data_bus_in[15:8]} : host_data_bus_in;

	// Register handshake pace is the input clock halved, also sent out as a pin.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			half   <= 1'b0;
			half_d <= 1'b0;
		end else begin
			half   <= ~half;
			half_d <= half;
		end
	end
	assign half_clk = half;

	reg_store #(.AW(`ADDR_WIDTH), .DW(`BYTE_WIDTH)) u_store (
		.clk   (core_clk),
		.we    (wr_en),
		.waddr (reg_addr),
		.wdata (wr_byte),
		.raddr (reg_addr),
		.rdata (rd_byte)
	);

	// Register cycle handshake: decode, complete, drive acknowledge high, release.
	// Stepping only on the halved tick keeps the timing of the original device.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state     <= ST_IDLE;
			ack_drive <= 1'b0;
			ack_low   <= 1'b0;
			bus_drive <= 1'b0;
			wr_en     <= 1'b0;
			wr_byte   <= 8'h00;
			host_data_bus_out <= 16'h0000;
			daisy_pass_n <= 1'b1;
		end else begin
			wr_en <= 1'b0;
			daisy_pass_n <= ~(svc_cycle & ~service_pending);
			if (tick) begin
				case (state)
				ST_IDLE: begin
					if (reg_cycle) begin
						if (read_write) begin
							bus_drive <= 1'b1;
						end else begin
							wr_en   <= 1'b1;
							wr_byte <= host_data_bus_in[7:0];
						end
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					host_data_bus_out <= {rd_byte, rd_byte};
					ack_drive <= 1'b1;
					ack_low   <= 1'b1;
					state     <= ST_DONE;
				end
				ST_DONE: begin
					if (data_strobe_n | chip_select_n) begin
						ack_low   <= 1'b0;
						bus_drive <= 1'b0;
						state     <= ST_REL;
					end
				end
				ST_REL: begin
					ack_drive <= 1'b0;
					state     <= ST_IDLE;
				end
				default: state <= ST_IDLE;
				endcase
			end
			if (dma_active & dma_to_memory) begin
				host_data_bus_out <= lane_order_select ?
					{dma_read_word[7:0], dma_read_word[15:8]} : dma_read_word;
			end
		end
	end
	assign transfer_acknowledge_n_out = ~ack_low;
	assign transfer_acknowledge_n_oe  = ack_drive & ~dma_active;
	assign host_data_bus_oe = (bus_drive & reg_cycle & read_write)
		| (dma_active & dma_to_memory);

	// DMA request and the sixteen-bit write path toward the FIFO.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dma_request_n    <= 1'b1;
			dma_ack_d        <= 1'b1;
			dma_write_word   <= 16'h0000;
			dma_write_strobe <= 1'b0;
		end else begin
			dma_ack_d        <= dma_acknowledge_n;
			dma_write_strobe <= 1'b0;
			if (dma_ack_d & ~dma_acknowledge_n & fifo_last_transfer) begin
				dma_request_n <= 1'b1;
			end else if (dma_enable_bit & fifo_wants_transfer & dma_acknowledge_n) begin
				dma_request_n <= 1'b0;
			end else if (~dma_enable_bit) begin
				dma_request_n <= 1'b1;
			end
			if ((dma_ack_d & ~dma_acknowledge_n & ~dma_to_memory)
				| (tick & state == ST_IDLE & reg_cycle & ~read_write & is_dma_buffer_register)) begin
				dma_write_word   <= lane_in;
				dma_write_strobe <= 1'b1;
			end
		end
	end

	// Service request only ever pulls low.
	assign service_request_n_out = 1'b0;
	assign service_request_n_oe  = service_pending & ~rst;

	// Parallel side outputs always hold their reset levels; no protocol logic drives them.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			host_busy_reply          <= `RST_HOST_BUSY_REPLY;
			strobe_reply             <= `RST_STROBE_REPLY;
			acknowledge_data_request <= `RST_ACK_DATA_REQ;
			extension_flag           <= `RST_EXT_FLAG;
			data_available_n         <= `RST_DATA_AVAIL_N;
			buffer_direction         <= `RST_BUF_DIRECTION;
			buffer_enable            <= `RST_BUF_ENABLE;
		end else begin
			host_busy_reply          <= `RST_HOST_BUSY_REPLY;
			strobe_reply             <= `RST_STROBE_REPLY;
			acknowledge_data_request <= `RST_ACK_DATA_REQ;
			extension_flag           <= `RST_EXT_FLAG;
			data_available_n         <= `RST_DATA_AVAIL_N;
			buffer_direction         <= `RST_BUF_DIRECTION;
			buffer_enable            <= `RST_BUF_ENABLE;
		end
	end
	assign cable_data_lines_oe      = 1'b0;
	assign general_purpose_lines_oe = 1'b0;
endmodule // cpu_bus_host_port
`default_nettype wire

// *** cpu_bus_host_port_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "host_port_consts.vh"
module cpu_bus_host_port_bench;
	logic core_clk, rst, half_clk, chip_select_n, data_strobe_n, read_write, lane_order_select;
	logic [6:0] reg_addr;
	logic [15:0] host_data_bus_in, host_data_bus_out, dma_read_word, dma_write_word, last_wr, rd;
	logic host_data_bus_oe, transfer_acknowledge_n_out, transfer_acknowledge_n_oe, dma_request_n;
	logic dma_acknowledge_n, dma_enable_bit, dma_to_memory, fifo_wants_transfer, fifo_last_transfer;
	logic dma_write_strobe, service_pending, service_request_n_out, service_request_n_oe;
	logic service_acknowledge_n, daisy_grant_n, daisy_pass_n, host_busy_reply, strobe_reply;
	logic acknowledge_data_request, extension_flag, data_available_n, buffer_direction;
	logic buffer_enable, cable_data_lines_oe, general_purpose_lines_oe;
	logic [3:0] delay;
	int error_cnt, check_count, cycles, wr_cnt;
	cpu_bus_host_port cpu_bus_host_port_inst (.*);
	dma_ctrl_model dma_ctrl_model_inst (.*);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Count cycles for the hang limit and keep each word handed to the FIFO side.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (dma_write_strobe === 1'b1) begin
			last_wr <= dma_write_word;
			wr_cnt <= wr_cnt + 1;
		end
		if (cycles == 3000) begin
			error_cnt = error_cnt + 1;
			close_out();
		end
	end
	task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic close_out;
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One register cycle: hold select and strobe until acknowledged, then wait for release.
	task automatic reg_cycle(input logic [6:0] a, input logic rw, input logic [15:0] wd);
		int n;
		@(negedge core_clk);
		{reg_addr, read_write, host_data_bus_in} = {a, rw, wd};
		{chip_select_n, data_strobe_n} = 2'b00;
		for (n = 0; n < 20 && !(transfer_acknowledge_n_oe === 1'b1 &&
			transfer_acknowledge_n_out === 1'b0); n++) @(negedge core_clk);
		cmp(16'h0001, {15'h0, transfer_acknowledge_n_oe & ~transfer_acknowledge_n_out});
		rd = host_data_bus_out;
		data_strobe_n = 1'b1;
		for (n = 0; n < 20 && transfer_acknowledge_n_oe !== 1'b0; n++) @(negedge core_clk);
		cmp(16'h0000, {15'h0, transfer_acknowledge_n_oe});
		chip_select_n = 1'b1;
	endtask
	task automatic t_reset;
		rst = 1'b1;
		repeat (3) @(negedge core_clk);
		cmp(16'h3098, {2'b00, dma_request_n, daisy_pass_n, host_data_bus_oe,
			transfer_acknowledge_n_oe, service_request_n_oe, host_busy_reply, strobe_reply,
			acknowledge_data_request, extension_flag, data_available_n, buffer_direction,
			buffer_enable, cable_data_lines_oe, general_purpose_lines_oe});
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		cmp(16'h0000, {15'h0, service_request_n_out});
	endtask
	task automatic t_reg;
		int w;
		w = wr_cnt;
		lane_order_select = 1'b1;
		reg_cycle(7'h05, 1'b0, 16'hA55A);
		reg_cycle(7'h05, 1'b1, 16'h0000);
		cmp(16'h5A5A, rd);
		cmp(w[15:0], wr_cnt[15:0]);
	endtask
	task automatic t_buf;
		int l;
		for (l = 0; l < 2; l++) begin
			lane_order_select = l[0];
			reg_cycle(`DMA_BUFFER_ADDR, 1'b0, 16'hBEEF);
			repeat (2) @(negedge core_clk);
			cmp(l[0] ? 16'hEFBE : 16'hBEEF, last_wr);
		end
	endtask
	// Both directions, both lane orders, prompt and slow grants; select stays high throughout.
	task automatic t_dma;
		int i, n;
		for (i = 0; i < 4; i++) begin
			@(negedge core_clk);
			{dma_to_memory, lane_order_select} = i[1:0];
			delay = i[1] ? 4'h5 : 4'h0;
			{data_strobe_n, read_write, host_data_bus_in} = {2'b01, 16'hC3A5};
			fifo_wants_transfer = 1'b1;
			for (n = 0; n < 30 && dma_acknowledge_n !== 1'b0; n++) @(negedge core_clk);
			fifo_wants_transfer = 1'b0;
			repeat (2) @(negedge core_clk);
			if (i[1])
				cmp(i[0] ? 16'h3412 : 16'h1234, host_data_bus_out);
			else
				cmp(16'h0000, {15'h0, host_data_bus_oe});
			cmp(16'h0001, {15'h0, dma_request_n});
			for (n = 0; n < 30 && dma_acknowledge_n !== 1'b1; n++) @(negedge core_clk);
			data_strobe_n = 1'b1;
			repeat (2) @(negedge core_clk);
			if (!i[1])
				cmp(i[0] ? 16'hA5C3 : 16'hC3A5, last_wr);
		end
	endtask
	initial begin
		rst = 1'b1;
		{chip_select_n, data_strobe_n, read_write, lane_order_select} = 4'hE;
		{reg_addr, host_data_bus_in, dma_read_word, delay} = {7'h00, 16'h0000, 16'h1234, 4'h0};
		{dma_enable_bit, dma_to_memory, fifo_wants_transfer, fifo_last_transfer} = 4'h9;
		{service_pending, service_acknowledge_n, daisy_grant_n, last_wr} = {3'b011, 16'h0000};
		{error_cnt, check_count, cycles, wr_cnt} = 0;
		t_reset();
		t_reg();
		t_buf();
		t_dma();
		t_reset();
		t_reg();
		close_out();
	end
endmodule // cpu_bus_host_port_bench
`default_nettype wire

// *** cpu_bus_host_port_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_host_port_chk (
	input wire logic        core_clk,                   // Clock.
	input wire logic        rst,                        // Reset.
	input wire logic        half_clk,                   // Halved clock.
	input wire logic        chip_select_n,              // Select.
	input wire logic        data_strobe_n,              // Strobe.
	input wire logic        read_write,                 // Direction.
	input wire logic        lane_order_select,          // Lane order.
	input wire logic [15:0] host_data_bus_out,          // Bus data.
	input wire logic        host_data_bus_oe,           // Bus drive.
	input wire logic        transfer_acknowledge_n_out, // Ack level.
	input wire logic        transfer_acknowledge_n_oe,  // Ack drive.
	input wire logic        dma_request_n,              // Request.
	input wire logic        dma_acknowledge_n,          // Grant.
	input wire logic        dma_to_memory,              // DMA direction.
	input wire logic        fifo_last_transfer,         // Last word.
	input wire logic [15:0] dma_read_word,              // FIFO word.
	input wire logic        service_request_n_oe        // Pull-down.
);
	// Acknowledge pulled low, and a register request seen on the pins.
	wire ack_low = transfer_acknowledge_n_oe && !transfer_acknowledge_n_out;
	wire reg_req = !chip_select_n && !data_strobe_n && dma_acknowledge_n;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// The acknowledge ends with a short high drive before letting go.
	sequence ack_ends; ack_low ##1 !ack_low; endsequence
	sequence ack_lets_go;
		transfer_acknowledge_n_oe && transfer_acknowledge_n_out ##[1:3] !transfer_acknowledge_n_oe;
	endsequence
	a_half_clk_toggles: assert property (!$past(rst) |-> half_clk != $past(half_clk))
		else $error("halved clock did not toggle");
	a_ack_release: assert property (ack_ends |-> ack_lets_go)
		else $error("acknowledge not actively released");
	a_ack_bounded: assert property (reg_req && !transfer_acknowledge_n_oe |-> ##[1:8] ack_low)
		else $error("register cycle not acknowledged");
	a_ack_cause: assert property ($rose(ack_low) |-> $past(reg_req, 2))
		else $error("acknowledge without select and strobe");
	a_no_ack_dma: assert property (!dma_acknowledge_n |-> !ack_low)
		else $error("acknowledge during DMA");
	a_read_lanes: assert property (ack_low && read_write && reg_req |-> host_data_bus_oe &&
		host_data_bus_out[15:8] == host_data_bus_out[7:0]) else $error("read lanes differ");
	a_bus_cause: assert property (host_data_bus_oe |->
		(!dma_acknowledge_n && dma_to_memory) || (!chip_select_n && read_write))
		else $error("bus driven without cause");
	a_dma_lanes: assert property ($fell(dma_acknowledge_n) && dma_to_memory |-> ##2
		host_data_bus_oe && host_data_bus_out == (lane_order_select ?
		{dma_read_word[7:0], dma_read_word[15:8]} : dma_read_word)) else $error("DMA lanes wrong");
	a_req_drop: assert property ($fell(dma_acknowledge_n) && fifo_last_transfer |->
		##[0:1] dma_request_n) else $error("request kept after last grant");
	a_reset_idle: assert property (disable iff (1'b0) rst |-> dma_request_n &&
		!host_data_bus_oe && !transfer_acknowledge_n_oe && !service_request_n_oe)
		else $error("outputs not idle in reset");
endmodule // cpu_bus_host_port_chk
bind cpu_bus_host_port cpu_bus_host_port_chk cpu_bus_host_port_chk_inst (.*);
`default_nettype wire

// *** dma_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dma_ctrl_model (
	input wire logic       core_clk,          // Clock.
	input wire logic       rst,               // Reset.
	input wire logic       dma_request_n,     // Request from the port.
	input wire logic [3:0] delay,             // Cycles to wait before granting.
	output var logic       dma_acknowledge_n  // Grant, held three cycles.
);
	logic [3:0] cnt;
	// Grant only after a request, after a chosen delay, so slow and fast answers both occur.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dma_acknowledge_n <= 1'b1;
			cnt <= 4'h0;
		end else if (!dma_acknowledge_n) begin
			cnt <= (cnt == 4'h2) ? 4'h0 : cnt + 4'h1;
			dma_acknowledge_n <= (cnt == 4'h2);
		end else if (!dma_request_n) begin
			cnt <= (cnt == delay) ? 4'h0 : cnt + 4'h1;
			dma_acknowledge_n <= (cnt != delay);
		end
	end
endmodule // dma_ctrl_model
`default_nettype wire

// *** host_port_consts.vh ***
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
// Address of the DMA buffer register within the 7-bit map.
`define DMA_BUFFER_ADDR     7'h00
// Service acknowledge address; unused, the port decodes service acknowledge cycles without the address.
`define SVC_ACK_ADDR        7'h7F
// Width of the register address.
`define ADDR_WIDTH          7
// Byte width and bus width.
`define BYTE_WIDTH          8
`define BUS_WIDTH           16
// Reset levels of the parallel side outputs.
`define RST_HOST_BUSY_REPLY 1'b0
`define RST_STROBE_REPLY    1'b1
`define RST_ACK_DATA_REQ    1'b0
`define RST_EXT_FLAG        1'b0
`define RST_DATA_AVAIL_N    1'b1
`define RST_BUF_DIRECTION   1'b1
`define RST_BUF_ENABLE      1'b0
// Register file depth, one 8-bit word per address.
`define REG_DEPTH           128
`endif

// *** reg_store.v ***
`timescale 1ns/100ps
`default_nettype none
// Small register store; read data come out of a flip-flop.
module reg_store #(
	parameter AW = 7,
	parameter DW = 8
) (
	input  wire          clk,     // Internal clock.
	input  wire          we,      // Write strobe.
	input  wire [AW-1:0] waddr,   // Write address.
	input  wire [DW-1:0] wdata,   // Write data.
	input  wire [AW-1:0] raddr,   // Read address.
	output reg  [DW-1:0] rdata    // Registered read data.
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Write and registered read on the same edge.
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // reg_store
`default_nettype wire
